// >>> bench/edma_far_model.sv
`timescale 1ns/10ps
module edma_far_model
	import edma_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_slow,
	input  wire logic        i_bus_req,
	input  wire logic        i_rd,
	input  wire logic        i_wr,
	input  wire edma_space_e i_space,
	input  wire logic [23:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	output logic             o_gnt,
	output logic             o_ack,
	output logic [7:0]       o_rdata
);
	logic [7:0]  mem [0:4095];
	logic [23:0] wlog [$];
	logic [1:0]  wait_reg;

	// Processor hands the bus over one cycle late, like a real arbiter
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_gnt <= 1'b0;
		end else begin
			o_gnt <= i_bus_req;
		end
	end

	// Read data is only meaningful with ack; it toggles otherwise so stale samples show
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_ack <= 1'b0;
			wait_reg <= 2'h0;
			o_rdata <= 8'h00;
		end else if (!o_ack && (i_rd || i_wr) && wait_reg == 2'h0) begin
			o_ack <= 1'b1;
			wait_reg <= i_slow ? 2'($urandom_range(2, 0)) : 2'h0;
			if (i_rd) begin
				o_rdata <= mem[{i_space, i_addr[9:0]}];
			end else begin
				mem[{i_space, i_addr[9:0]}] <= i_wdata;
				wlog.push_back(i_addr);
			end
		end else begin
			o_ack <= 1'b0;
			o_rdata <= ~o_rdata;
			if (!o_ack && (i_rd || i_wr)) begin
				wait_reg <= wait_reg - 2'h1;
			end
		end
	end
endmodule

// >>> bench/edma_top_test.sv
`timescale 1ns/10ps
module edma_top_test
	import edma_pkg::*;
;
	logic        clk, arst_n, start, slow, gnt, ack, breq, bypass, rd, wr;
	logic [1:0]  xpri, cpri, ilvl, bpri, olvl;
	edma_arb_e   arb;
	edma_space_e space, ss, ds;
	logic [7:0]  burst, gap, mbyte, mmask, chreq, rdata, iack, wdata, active, irq, f, e;
	logic [15:0] tdiv;
	logic [2:0]  sch;
	logic [23:0] daddr, addr, sa, da;
	logic [3:0]  w;
	int          error_cnt, compares, gap_run, gap_min, rises, n;

	edma_top u_edma_top (.I_CLOCK(clk), .I_ARST_N(arst_n), .I_XFER_PRI(xpri), .I_CPU_PRI(cpri),
		.I_IRQ_LEVEL(ilvl), .I_ARB_MODE(arb), .I_BURST_SIZE(burst), .I_GAP_MIN(gap), .I_TIMER_DIV(tdiv),
		.I_MATCH_BYTE(mbyte), .I_MATCH_MASK(mmask), .I_START(start), .I_START_CH(sch), .I_DESC_ADDR(daddr),
		.I_CH_REQ(chreq), .I_BUS_GNT(gnt), .I_ACK(ack), .I_RDATA(rdata), .I_IRQ_ACK(iack),
		.O_BUS_REQ(breq), .O_MMU_BYPASS(bypass), .O_BUS_PRI(bpri), .O_RD(rd), .O_WR(wr), .O_SPACE(space),
		.O_ADDR(addr), .O_WDATA(wdata), .O_CH_ACTIVE(active), .O_IRQ_REQ(irq), .O_IRQ_LEVEL(olvl));

	edma_far_model u_edma_far_model (.i_clk(clk), .i_arst_n(arst_n), .i_slow(slow), .i_bus_req(breq),
		.i_rd(rd), .i_wr(wr), .i_space(space), .i_addr(addr), .i_wdata(wdata), .o_gnt(gnt), .o_ack(ack),
		.o_rdata(rdata));

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic complete_run();
		if (error_cnt == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	function automatic logic [7:0] mb(input edma_space_e s, input logic [23:0] a);
		return u_edma_far_model.mem[{s, a[9:0]}];
	endfunction

	task automatic pb(input edma_space_e s, input logic [23:0] a, input logic [7:0] d);
		u_edma_far_model.mem[{s, a[9:0]}] = d;
	endtask

	task automatic wdesc(input logic [23:0] b, input logic [7:0] fl, md, input logic [15:0] c,
		input logic [23:0] s, d);
		logic [79:0] v;
		v = {d, s, c, md, fl};
		for (int i = 0; i < 10; i++) pb(SP_MEM, b + 24'(i), v[8*i +: 8]);
	endtask

	task automatic go(input logic [2:0] ch, input logic [23:0] b);
		@(posedge clk);
		start <= 1'b1;
		sch <= ch;
		daddr <= b;
		@(posedge clk);
		start <= 1'b0;
	endtask

	task automatic settle();
		int k;
		k = 0;
		repeat (2) @(posedge clk);
		while (active !== 8'h00 && k < 4000) begin
			@(posedge clk);
			k++;
		end
		repeat (3) @(negedge clk);
		check("idle", k < 4000, 1);
	endtask

	// Bus ownership and physical addressing during every access
	always @(negedge clk) begin
		if (rd || wr) check("own", {bypass, breq}, 2'h3);
	end

	// Counts bus request rises and the shortest release between them
	always @(posedge clk) begin
		if (breq) begin
			if (gap_run != 0) rises++;
			if (gap_run > 0 && gap_run < gap_min) gap_min = gap_run;
			gap_run = 0;
		end else if (gap_run >= 0) begin
			gap_run++;
		end
	end

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#500us;
		error_cnt++;
		complete_run();
	end

	initial begin
		{arst_n, start, slow, cpri, ilvl, mbyte, mmask, iack, sch, daddr, gap} = '0;
		arb = arb_fixed;
		{xpri, burst, chreq, tdiv} = {2'h3, 8'h0, 8'hff, 16'h0};
		{error_cnt, compares, gap_run} = {32'h0, 32'h0, 32'h0};
		e = 8'($urandom(32'hfafd780e));
		repeat (10) @(posedge clk);
		check("rst", {breq, rd, wr, active, irq, olvl}, 21'h1);
		arst_n <= 1'b1;
		for (int l = 0; l < 4; l++) begin
			@(posedge clk);
			xpri <= 2'(l);
			ilvl <= 2'(l);
			repeat (2) @(negedge clk);
			check("pri", {bpri, olvl}, {2'(l), (l == 0) ? 2'h1 : 2'(l)});
		end
		@(posedge clk);
		xpri <= 2'h3;
		for (int c = 0; c < 8; c++) begin
			n = $urandom_range(6, 1);
			f = {3'h0, 2'($urandom), 1'b0, 1'($urandom), 1'b0};
			@(posedge clk);
			burst <= 8'($urandom_range(3, 0));
			gap <= 8'($urandom_range(4, 0));
			slow <= 1'($urandom);
			arb <= edma_arb_e'($urandom_range(2, 0));
			for (int i = 0; i < 8; i++) begin
				pb(SP_MEM, 24'h100 + 24'(i), 8'($urandom));
				pb(SP_MEM, 24'h200 + 24'(i), 8'h00);
			end
			sa = f[3] ? 24'h107 : 24'h100;
			da = f[4] ? 24'h207 : 24'h200;
			wdesc(24'h010, f, 8'h00, 16'(n), sa, da);
			go(3'(c), 24'h010);
			settle();
			for (int i = 0; i < n; i++) begin
				check("copy", mb(SP_MEM, da), mb(SP_MEM, sa));
				sa = f[3] ? sa - 24'h1 : sa + 24'h1;
				da = f[4] ? da - 24'h1 : da + 24'h1;
			end
			check("irq", irq, {7'h0, f[1]} << c);
			@(posedge clk);
			iack <= 8'hff;
			@(posedge clk);
			iack <= 8'h00;
			repeat (2) @(negedge clk);
			check("irqclr", irq, 8'h00);
		end
		for (int k = 1; k < 5; k++) begin
			ss = (k == 1) ? SP_IOI : (k == 3) ? SP_IOE : SP_MEM;
			ds = (k == 2) ? SP_IOI : (k == 4) ? SP_IOE : SP_MEM;
			for (int i = 0; i < 4; i++) begin
				pb(ss, 24'h30 + 24'(i), 8'($urandom));
				pb(ds, 24'h40 + 24'(i), 8'h00);
			end
			wdesc(24'h080, (k < 3) ? 8'h04 : 8'h00, 8'(k), 16'h3, 24'h30, 24'h40);
			go(3'h3, 24'h080);
			settle();
			if (ss != SP_MEM) begin
				for (int i = 0; i < 3; i++) check("in", mb(ds, 24'h40 + 24'(i)), mb(ss, 24'h30));
			end else begin
				check("out", mb(ds, 24'h40), mb(ss, (k == 2) ? 24'h31 : 24'h32));
			end
			if (k == 1) check("status", mb(SP_MEM, 24'h08d), mb(ss, 24'h31));
			if (k == 2) check("last", mb(ds, 24'h41), mb(ss, 24'h32));
		end
		@(posedge clk);
		mbyte <= 8'h50;
		mmask <= 8'hf0;
		for (int i = 0; i < 6; i++) begin
			pb(SP_MEM, 24'h100 + 24'(i), (i == 2) ? (8'h50 | (e & 8'h0f)) : (8'($urandom) & 8'h4f));
			pb(SP_MEM, 24'h200 + 24'(i), 8'hee);
		end
		wdesc(24'h0a0, 8'h20, 8'h00, 16'h6, 24'h100, 24'h200);
		go(3'h6, 24'h0a0);
		settle();
		for (int i = 0; i < 6; i++) begin
			e = (i < 3) ? mb(SP_MEM, 24'h100 + 24'(i)) : 8'hee;
			check("match", mb(SP_MEM, 24'h200 + 24'(i)), e);
		end
		// Two-byte bursts in each arbitration mode, back-to-back starts held off by processor priority
		for (int m = 0; m < 3; m++) begin
			@(posedge clk);
			arb <= edma_arb_e'(m);
			cpri <= 2'h3;
			burst <= 8'h02;
			gap <= 8'h03;
			wdesc(24'h040, 8'h00, 8'h00, 16'h2, 24'h100, 24'h600);
			wdesc(24'h050, 8'h00, 8'h00, 16'h2, 24'h100, 24'h700);
			go(3'h2, 24'h040);
			go(3'h5, 24'h050);
			repeat (20) @(negedge clk);
			check("held", {breq, active}, 9'h024);
			u_edma_far_model.wlog.delete();
			@(posedge clk);
			cpri <= 2'h0;
			settle();
			for (int i = 0; i < 4; i++) w[3 - i] = u_edma_far_model.wlog[i][8];
			check("order", (m == 0) ? w : {w[3] ^ w[2], w[2] ^ w[1], w[1] ^ w[0]}, (m == 0) ? 4'hc : (m == 1) ? 3'h7 : 3'h2);
		end
		@(posedge clk);
		arb <= arb_fixed;
		gap <= 8'h05;
		slow <= 1'b0;
		{rises, gap_run, gap_min} = {32'h0, -32'sd1, 32'd1000};
		wdesc(24'h060, 8'h00, 8'h00, 16'h5, 24'h100, 24'h200);
		go(3'h1, 24'h060);
		settle();
		check("bursts", rises, 3);
		check("gap", gap_min >= 5, 1);
		@(posedge clk);
		tdiv <= 16'h0014;
		gap <= 8'h00;
		burst <= 8'h04;
		rises = 0;
		gap_run = -1;
		wdesc(24'h060, 8'hc0, 8'h00, 16'h3, 24'h100, 24'h200);
		go(3'h0, 24'h060);
		settle();
		check("paced", rises >= 3, 1);
		wdesc(24'h0c0, 8'h01, 8'h00, 16'h2, 24'h100, 24'h200);
		u_edma_far_model.wlog.delete();
		go(3'h4, 24'h0c0);
		repeat (300) @(negedge clk);
		check("cycle", {active[4], u_edma_far_model.wlog.size() > 4}, 2'h3);
		pb(SP_MEM, 24'h0c0, 8'h00);
		settle();
		complete_run();
	end
endmodule

// >>> rtl/edma_params.svh
`ifndef EDMA_PARAMS_SVH
`define EDMA_PARAMS_SVH

`define EDMA_CHANNELS         8
`define EDMA_DESC_LEN_SHORT   4'h9
`define EDMA_DESC_LEN_LONG    4'hc
`define EDMA_STATUS_SRC_OFS   24'h000001
`define EDMA_STATUS_DESC_OFS  24'h00000d
`define EDMA_LAST_DST_OFS     24'h000001
`define EDMA_RST_ADDR         24'h000000
`define EDMA_RST_TOP          3'h7
`define EDMA_RST_GAP_SEEN     8'hff
`define EDMA_RST_IRQ_LEVEL    2'h1

`endif

// >>> rtl/edma_pkg.sv
package edma_pkg;

	typedef enum logic [3:0] {
		S_IDLE   = 4'h0,
		S_WAITG  = 4'h1,
		S_NEXT   = 4'h2,
		S_FETCH  = 4'h3,
		S_SREAD  = 4'h4,
		S_SWRITE = 4'h5,
		S_READ   = 4'h6,
		S_WRITE  = 4'h7,
		S_GAP    = 4'h8
	} edma_state_e;

	typedef enum logic [2:0] {
		K_MEM2MEM = 3'h0,
		K_IOI2MEM = 3'h1,
		K_MEM2IOI = 3'h2,
		K_IOE2MEM = 3'h3,
		K_MEM2IOE = 3'h4
	} edma_kind_e;

	typedef enum logic [1:0] {
		arb_fixed              = 2'h0,
		arb_rotate_per_byte    = 2'h1,
		arb_rotate_per_request = 2'h2
	} edma_arb_e;

	typedef enum logic [1:0] {
		SP_MEM = 2'h0,
		SP_IOI = 2'h1,
		SP_IOE = 2'h2
	} edma_space_e;

	typedef struct packed {
		logic opt_timer_single_byte;
		logic timer;
		logic stop_match;
		logic opt_destination_down;
		logic opt_source_down;
		logic opt_frame_last_handling;
		logic irq;
		logic cyc_repeat;
	} edma_flags_s;

	typedef struct packed {
		logic [3:0] rsvd;
		logic       link_en;
		edma_kind_e kind;
	} edma_mode_s;

	// Byte 0 of the descriptor sits in the low bits
	typedef struct packed {
		logic [23:0] link;
		logic [23:0] dst;
		logic [23:0] src;
		logic [15:0] cnt;
		edma_mode_s  mode;
		edma_flags_s flags;
	} edma_desc_s;

	typedef struct packed {
		logic        rd;
		logic        wr;
		edma_space_e space;
		logic [23:0] addr;
		logic [7:0]  wdata;
	} edma_bus_s;

	typedef struct packed {
		logic       found;
		logic [2:0] idx;
	} edma_pick_s;

endpackage

// >>> rtl/edma_top.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Eight identical channels move data without processor involvement.
// - While transferring, the controller owns the address and data bus.
// - All channel addresses are physical and bypass MMU translation.
// - Fixed arbitration: higher-numbered pending channel wins at each new request.
// - Per-byte rotation: priority order rotates after every byte moved.
// - Per-request rotation: priority rotates after each burst-sized request.
// - Priority, interrupt level, arbitration, burst size, gap are global.
// - Bus transfer priority is programmable from 0 through 3.
// - Completion interrupts share one level, 1, 2 or 3.
// - Interrupt only when selected; each channel has its own vector.
// - Channel follows an in-memory descriptor: control, count, addresses, link.
// - Burst and single-cycle modes, burst length from burst size.
// - Memory-memory and memory to/from internal or external I/O.
// - Decrement option steps a memory address downward per byte.
// - Stop-on-match ends the transfer when masked byte equals match byte.
// - Timer pacing requests; option limits each timed request to one byte.
// - Special-last: status to descriptor before last; last byte at offset.
// - Repeat restarts the descriptor instead of stopping at count end.
`include "edma_params.svh"

module edma_top
	import edma_pkg::*;
(
	input  wire logic        I_CLOCK,
	input  wire logic        I_ARST_N,
	input  wire logic [1:0]  I_XFER_PRI,
	input  wire logic [1:0]  I_CPU_PRI,
	input  wire logic [1:0]  I_IRQ_LEVEL,
	input  wire edma_arb_e   I_ARB_MODE,
	input  wire logic [7:0]  I_BURST_SIZE,
	input  wire logic [7:0]  I_GAP_MIN,
	input  wire logic [15:0] I_TIMER_DIV,
	input  wire logic [7:0]  I_MATCH_BYTE,
	input  wire logic [7:0]  I_MATCH_MASK,
	input  wire logic        I_START,
	input  wire logic [2:0]  I_START_CH,
	input  wire logic [23:0] I_DESC_ADDR,
	input  wire logic [7:0]  I_CH_REQ,
	input  wire logic        I_BUS_GNT,
	input  wire logic        I_ACK,
	input  wire logic [7:0]  I_RDATA,
	input  wire logic [7:0]  I_IRQ_ACK,
	output logic             O_BUS_REQ,
	output logic             O_MMU_BYPASS,
	output logic [1:0]       O_BUS_PRI,
	output logic             O_RD,
	output logic             O_WR,
	output edma_space_e      O_SPACE,
	output logic [23:0]      O_ADDR,
	output logic [7:0]       O_WDATA,
	output logic [7:0]       O_CH_ACTIVE,
	output logic [7:0]       O_IRQ_REQ,
	output logic [1:0]       O_IRQ_LEVEL
);

	edma_state_e state_reg;
	logic [2:0]  cur_reg;
	logic [2:0]  top_reg;
	logic [3:0]  fidx_reg;
	logic [7:0]  burst_cnt_reg;
	logic [7:0]  gap_cnt_reg;
	logic        bus_req_reg;
	edma_bus_s   bus_reg;
	logic        match_reg;
	edma_desc_s  desc_q [0:`EDMA_CHANNELS-1];
	logic [23:0] base_q [0:`EDMA_CHANNELS-1];
	logic [7:0]  active_reg;
	logic [7:0]  need_fetch_reg;
	logic [7:0]  status_done_reg;
	logic [7:0]  credit_reg;
	logic [7:0]  done_reg;
	logic [7:0]  irq_pend_reg;
	logic [1:0]  irq_level_reg;
	logic [1:0]  bus_pri_reg;
	logic [15:0] tdiv_cnt_reg;
	logic        tick_reg;
	logic [7:0]  elig;
	logic [7:0]  tick_mask;
	logic [7:0]  burst_len;
	logic        pri_ok;
	edma_desc_s  cur_d;
	edma_pick_s  pick_idle;
	edma_pick_s  pick_go;
	edma_desc_s  go_d;
	logic        go_special;
	logic        last_byte;
	logic [23:0] dst_eff;

	function automatic edma_pick_s arb(input logic [7:0] el, input logic [2:0] top);
		edma_pick_s p;
		logic [2:0] k;
		p = '0;
		for (int i = 0; i < 8; i++) begin
			k = top - i[2:0];
			if (!p.found && el[k]) begin
				p.found = 1'b1;
				p.idx = k;
			end
		end
		return p;
	endfunction

	function automatic logic [23:0] step(input logic [23:0] a, input logic down);
		return down ? a - 24'h1 : a + 24'h1;
	endfunction

	function automatic edma_space_e src_sp(input edma_kind_e k);
		case (k)
			K_IOI2MEM: return SP_IOI;
			K_IOE2MEM: return SP_IOE;
			default:   return SP_MEM;
		endcase
	endfunction

	function automatic edma_space_e dst_sp(input edma_kind_e k);
		case (k)
			K_MEM2IOI: return SP_IOI;
			K_MEM2IOE: return SP_IOE;
			default:   return SP_MEM;
		endcase
	endfunction

	function automatic edma_bus_s mk_bus(input logic rd, input logic wr, input edma_space_e sp,
		input logic [23:0] a, input logic [7:0] d);
		edma_bus_s b;
		b.rd = rd;
		b.wr = wr;
		b.space = sp;
		b.addr = a;
		b.wdata = d;
		return b;
	endfunction

	// Untimed I/O channels wait for their peripheral; timed channels only for a credit
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			tick_mask[i] = tick_reg & desc_q[i].flags.timer;
			elig[i] = active_reg[i] & (need_fetch_reg[i] | (desc_q[i].flags.timer ? credit_reg[i] :
				(desc_q[i].mode.kind == K_MEM2MEM || I_CH_REQ[i])));
		end
	end

	assign pri_ok = I_XFER_PRI > I_CPU_PRI;
	assign burst_len = (I_BURST_SIZE == 8'h0) ? 8'h1 : I_BURST_SIZE;
	assign cur_d = desc_q[cur_reg];
	assign pick_idle = arb(elig, (I_ARB_MODE == arb_fixed) ? `EDMA_RST_TOP : top_reg);
	// Fixed and per-request modes keep the channel for the whole burst
	assign pick_go = (I_ARB_MODE == arb_rotate_per_byte) ? arb(elig, top_reg) :
		edma_pick_s'{found: elig[cur_reg], idx: cur_reg};
	assign go_d = desc_q[pick_go.idx];
	assign go_special = go_d.flags.opt_frame_last_handling && go_d.mode.kind == K_IOI2MEM &&
		go_d.cnt == 16'h1 && !status_done_reg[pick_go.idx];
	assign last_byte = cur_d.cnt == 16'h1 || match_reg;
	assign dst_eff = (cur_d.flags.opt_frame_last_handling && cur_d.mode.kind == K_MEM2IOI && cur_d.cnt == 16'h1) ?
		cur_d.dst + `EDMA_LAST_DST_OFS : cur_d.dst;

	always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			tdiv_cnt_reg <= 16'h0;
			tick_reg <= 1'b0;
		end else if (tdiv_cnt_reg >= I_TIMER_DIV) begin
			tdiv_cnt_reg <= 16'h0;
			tick_reg <= 1'b1;
		end else begin
			tdiv_cnt_reg <= tdiv_cnt_reg + 16'h1;
			tick_reg <= 1'b0;
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			state_reg <= S_IDLE;
			cur_reg <= 3'h0;
			top_reg <= `EDMA_RST_TOP;
			fidx_reg <= 4'h0;
			burst_cnt_reg <= 8'h0;
			gap_cnt_reg <= 8'h0;
			bus_req_reg <= 1'b0;
			bus_reg <= '0;
			match_reg <= 1'b0;
			active_reg <= 8'h0;
			need_fetch_reg <= 8'h0;
			status_done_reg <= 8'h0;
			credit_reg <= 8'h0;
			done_reg <= 8'h0;
			for (int i = 0; i < 8; i++) begin
				desc_q[i] <= '0;
				base_q[i] <= `EDMA_RST_ADDR;
			end
		end else begin
			done_reg <= 8'h0;
			credit_reg <= credit_reg | tick_mask;
			case (state_reg)
				S_IDLE: begin
					if (pick_idle.found && pri_ok) begin
						bus_req_reg <= 1'b1;
						cur_reg <= pick_idle.idx;
						burst_cnt_reg <= 8'h0;
						state_reg <= S_WAITG;
					end
				end
				S_WAITG: begin
					if (I_BUS_GNT) begin
						state_reg <= S_NEXT;
					end
				end
				S_NEXT: begin
					if (!pri_ok || !pick_go.found || burst_cnt_reg >= burst_len) begin
						bus_req_reg <= 1'b0;
						gap_cnt_reg <= 8'h0;
						if (I_ARB_MODE == arb_rotate_per_request) begin
							top_reg <= cur_reg - 3'h1;
						end
						state_reg <= S_GAP;
					end else begin
						cur_reg <= pick_go.idx;
						if (need_fetch_reg[pick_go.idx]) begin
							fidx_reg <= 4'h0;
							bus_reg <= mk_bus(1'b1, 1'b0, SP_MEM, base_q[pick_go.idx], 8'h0);
							state_reg <= S_FETCH;
						end else if (go_special) begin
							bus_reg <= mk_bus(1'b1, 1'b0, src_sp(go_d.mode.kind), go_d.src + `EDMA_STATUS_SRC_OFS, 8'h0);
							state_reg <= S_SREAD;
						end else begin
							bus_reg <= mk_bus(1'b1, 1'b0, src_sp(go_d.mode.kind), go_d.src, 8'h0);
							state_reg <= S_READ;
						end
					end
				end
				S_FETCH: begin
					if (I_ACK) begin
						desc_q[cur_reg][{fidx_reg, 3'h0} +: 8] <= I_RDATA;
						if ((fidx_reg == `EDMA_DESC_LEN_SHORT && !cur_d.mode.link_en) ||
							fidx_reg == `EDMA_DESC_LEN_LONG) begin
							need_fetch_reg[cur_reg] <= 1'b0;
							status_done_reg[cur_reg] <= 1'b0;
							bus_reg <= '0;
							state_reg <= S_NEXT;
						end else begin
							fidx_reg <= fidx_reg + 4'h1;
							bus_reg.addr <= base_q[cur_reg] + {20'h0, fidx_reg} + 24'h1;
						end
					end
				end
				S_SREAD: begin
					if (I_ACK) begin
						bus_reg <= mk_bus(1'b0, 1'b1, SP_MEM, base_q[cur_reg] + `EDMA_STATUS_DESC_OFS, I_RDATA);
						state_reg <= S_SWRITE;
					end
				end
				S_SWRITE: begin
					if (I_ACK) begin
						status_done_reg[cur_reg] <= 1'b1;
						bus_reg <= mk_bus(1'b1, 1'b0, src_sp(cur_d.mode.kind), cur_d.src, 8'h0);
						state_reg <= S_READ;
					end
				end
				S_READ: begin
					if (I_ACK) begin
						match_reg <= cur_d.flags.stop_match &&
							(I_RDATA & I_MATCH_MASK) == (I_MATCH_BYTE & I_MATCH_MASK);
						bus_reg <= mk_bus(1'b0, 1'b1, dst_sp(cur_d.mode.kind), dst_eff, I_RDATA);
						state_reg <= S_WRITE;
					end
				end
				S_WRITE: begin
					if (I_ACK) begin
						bus_reg <= '0;
						match_reg <= 1'b0;
						burst_cnt_reg <= burst_cnt_reg + 8'h1;
						if (src_sp(cur_d.mode.kind) == SP_MEM) begin
							desc_q[cur_reg].src <= step(cur_d.src, cur_d.flags.opt_source_down);
						end
						if (dst_sp(cur_d.mode.kind) == SP_MEM) begin
							desc_q[cur_reg].dst <= step(cur_d.dst, cur_d.flags.opt_destination_down);
						end
						desc_q[cur_reg].cnt <= cur_d.cnt - 16'h1;
						if (I_ARB_MODE == arb_rotate_per_byte) begin
							top_reg <= cur_reg - 3'h1;
						end
						// Credit cleared per byte or per descriptor; a new tick still wins
						if (cur_d.flags.opt_timer_single_byte || last_byte) begin
							credit_reg[cur_reg] <= tick_mask[cur_reg];
						end
						if (last_byte) begin
							done_reg[cur_reg] <= cur_d.flags.irq;
							if (cur_d.flags.cyc_repeat) begin
								need_fetch_reg[cur_reg] <= 1'b1;
							end else if (cur_d.mode.link_en) begin
								base_q[cur_reg] <= cur_d.link;
								need_fetch_reg[cur_reg] <= 1'b1;
							end else begin
								active_reg[cur_reg] <= 1'b0;
							end
						end
						state_reg <= S_NEXT;
					end
				end
				S_GAP: begin
					if (gap_cnt_reg >= I_GAP_MIN) begin
						state_reg <= S_IDLE;
					end else begin
						gap_cnt_reg <= gap_cnt_reg + 8'h1;
					end
				end
				default: begin
					bus_req_reg <= 1'b0;
					bus_reg <= '0;
					state_reg <= S_IDLE;
				end
			endcase
			// Restarting a busy channel takes effect at its next step
			if (I_START) begin
				active_reg[I_START_CH] <= 1'b1;
				need_fetch_reg[I_START_CH] <= 1'b1;
				base_q[I_START_CH] <= I_DESC_ADDR;
			end
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			irq_pend_reg <= 8'h0;
			irq_level_reg <= `EDMA_RST_IRQ_LEVEL;
			bus_pri_reg <= 2'h0;
		end else begin
			irq_pend_reg <= (irq_pend_reg & ~I_IRQ_ACK) | done_reg;
			irq_level_reg <= (I_IRQ_LEVEL == 2'h0) ? `EDMA_RST_IRQ_LEVEL : I_IRQ_LEVEL;
			bus_pri_reg <= I_XFER_PRI;
		end
	end

	assign O_BUS_REQ = bus_req_reg;
	assign O_MMU_BYPASS = bus_req_reg;
	assign O_BUS_PRI = bus_pri_reg;
	assign O_RD = bus_reg.rd;
	assign O_WR = bus_reg.wr;
	assign O_SPACE = bus_reg.space;
	assign O_ADDR = bus_reg.addr;
	assign O_WDATA = bus_reg.wdata;
	assign O_CH_ACTIVE = active_reg;
	assign O_IRQ_REQ = irq_pend_reg;
	assign O_IRQ_LEVEL = irq_level_reg;

	logic [7:0] low_cnt_reg;
	always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			low_cnt_reg <= `EDMA_RST_GAP_SEEN;
		end else if (bus_req_reg) begin
			low_cnt_reg <= 8'h0;
		end else if (low_cnt_reg != 8'hff) begin
			low_cnt_reg <= low_cnt_reg + 8'h1;
		end
	end

	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (!I_ARST_N);

	sequence s_status_written;
		state_reg == S_SWRITE && I_ACK;
	endsequence

	sequence s_byte_done;
		state_reg == S_WRITE && I_ACK;
	endsequence

	strobe_owns_bus_a: assert property ((O_RD || O_WR) |-> O_BUS_REQ && O_MMU_BYPASS)
		else $error("bus strobe without ownership");
	gap_respected_a: assert property ($rose(bus_req_reg) |-> low_cnt_reg >= I_GAP_MIN)
		else $error("bus requested before gap elapsed");
	request_priority_a: assert property ($rose(bus_req_reg) |-> $past(I_XFER_PRI) > $past(I_CPU_PRI))
		else $error("bus requested at too low priority");
	fixed_highest_a: assert property ($rose(bus_req_reg) && $past(I_ARB_MODE) == arb_fixed
		|-> ($past(elig) >> cur_reg) == 8'h1)
		else $error("fixed arbitration skipped higher channel");
	fine_rotate_a: assert property (s_byte_done and I_ARB_MODE == arb_rotate_per_byte
		|=> top_reg == $past(cur_reg) - 3'h1)
		else $error("priority not rotated after byte");
	source_down_a: assert property (s_byte_done and cur_d.flags.opt_source_down
		and src_sp(cur_d.mode.kind) == SP_MEM |=> cur_d.src == $past(cur_d.src) - 24'h1)
		else $error("source address not decremented");
	match_stop_a: assert property (s_byte_done and match_reg and !cur_d.flags.cyc_repeat
		and !cur_d.mode.link_en and !I_START |=> !active_reg[cur_reg])
		else $error("match did not stop channel");
	repeat_reload_a: assert property (s_byte_done and cur_d.cnt == 16'h1 and cur_d.flags.cyc_repeat
		|=> active_reg[cur_reg] && need_fetch_reg[cur_reg])
		else $error("repeat channel did not restart");
	status_first_a: assert property (s_status_written |=> state_reg == S_READ ##1 !bus_reg.wr)
		else $error("last data not read after status");
	irq_raised_a: assert property (done_reg != 8'h0 |=> (irq_pend_reg & $past(done_reg)) == $past(done_reg))
		else $error("completion interrupt lost");
	irq_level_a: assert property (O_IRQ_LEVEL != 2'h0)
		else $error("interrupt level zero");

endmodule
